/* odc_defs.svh */
// Offsets, field positions, reset values and gain constants for odc block
// Functional notes
// - Read-only 7-bit gain code; zero is +18 dB, 0.5 dB steps, 0x24 is 0 dB.
// - Past -27 dB steps are 1 dB to -63 dB at 0x7E; 0x7F is reserved.
// - Page select is 8-bit read/write, resets to zero, any value selects page.
// - Error bit 1 clear: speaker short clears speaker power-up bit.
// - Error bit 0 clear and action bit set: headphone short clears both power bits.
// - Headphone bit 7 powers left driver, bit 6 right; both reset to zero.
// - Headphone short with protection: limit current if action 0, power down if 1.
// - Read-only status bit shows a live headphone short.
// - Two-bit common-mode field selects 1.35, 1.5, 1.65 or 1.8 V; resets zero.
// - Speaker register bit 7 powers speaker driver; error control may clear it.
`ifndef ODC_DEFS_SVH
`define ODC_DEFS_SVH
`define ODC_OFS_PAGE 8'h00
`define ODC_OFS_ERR 8'h1e
`define ODC_OFS_HP 8'h1f
`define ODC_OFS_SPK 8'h20
`define ODC_OFS_GAIN 8'h75
`define ODC_PAGE_GAIN 8'h00
`define ODC_PAGE_DRV 8'h01
`define ODC_RST_PAGE 8'h00
`define ODC_RST_ERR 8'h00
`define ODC_RST_HP 8'h04
`define ODC_RST_SPK 8'h06
`define ODC_BIT_SPK_KEEP 1
`define ODC_BIT_HP_KEEP 0
`define ODC_BIT_HPL 7
`define ODC_BIT_HPR 6
`define ODC_BIT_ACT 1
`define ODC_BIT_SHORT 0
`define ODC_BIT_SPK_PWR 7
`define ODC_HP_WMASK 8'hfe
`define ODC_ERR_WMASK 8'h03
`define ODC_SPK_WMASK 8'hfe
`define ODC_GAIN_RSVD 7'h7f
`endif

/* odc_pkg.sv */
// Types for the output driver control register block
package odc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } odc_req_t;
    typedef struct packed {
        logic hpl_on;
        logic hpr_on;
        logic spk_on;
        logic [1:0] cm_sel;
        logic hp_limit;
    } odc_drv_t;
endpackage

/* odc_regs.sv */
// Output driver control registers with short-circuit handling
`include "odc_defs.svh"
module odc_regs
    import odc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire odc_req_t req,
    input wire logic [6:0] gain_code,
    input wire logic hp_short,
    input wire logic spk_short,
    output logic [7:0] rdata,
    output logic [7:0] page,
    output odc_drv_t drv
);
    logic [7:0] page_reg, page_next;
    logic [7:0] err_reg, err_next;
    logic [7:0] hp_reg, hp_next;
    logic [7:0] spk_reg, spk_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [6:0] gain_reg, gain_next;
    logic limit_reg, limit_next;
    logic on_drv;

    assign on_drv = (page_reg == `ODC_PAGE_DRV);

    // Next register values from bus writes and short events
    always_comb begin
        page_next = page_reg;
        err_next = err_reg;
        hp_next = hp_reg;
        spk_next = spk_reg;
        gain_next = gain_code;
        if (req.wr && req.addr == `ODC_OFS_PAGE)
            page_next = req.wdata;
        if (req.wr && on_drv) begin
            case (req.addr)
                `ODC_OFS_ERR: err_next = req.wdata & `ODC_ERR_WMASK;
                `ODC_OFS_HP: hp_next = req.wdata & `ODC_HP_WMASK;
                `ODC_OFS_SPK: spk_next = req.wdata & `ODC_SPK_WMASK;
                default: ;
            endcase
        end
        // Short detection beats a same-cycle power-up write
        if (spk_short && !err_reg[`ODC_BIT_SPK_KEEP])
            spk_next[`ODC_BIT_SPK_PWR] = 1'b0;
        if (hp_short && !err_reg[`ODC_BIT_HP_KEEP]
            && hp_reg[`ODC_BIT_ACT]) begin
            hp_next[`ODC_BIT_HPL] = 1'b0;
            hp_next[`ODC_BIT_HPR] = 1'b0;
        end
        hp_next[`ODC_BIT_SHORT] = hp_short;
        limit_next = hp_short && !hp_reg[`ODC_BIT_ACT];
    end

    // Read data, one cycle after the read request
    always_comb begin
        rdata_next = 8'h00;
        if (req.rd) begin
            if (req.addr == `ODC_OFS_PAGE)
                rdata_next = page_reg;
            else if (page_reg == `ODC_PAGE_GAIN
                     && req.addr == `ODC_OFS_GAIN)
                rdata_next = {1'b0, gain_reg};
            else if (on_drv) begin
                case (req.addr)
                    `ODC_OFS_ERR: rdata_next = err_reg;
                    `ODC_OFS_HP: rdata_next = hp_reg;
                    `ODC_OFS_SPK: rdata_next = spk_reg;
                    default: rdata_next = 8'h00;
                endcase
            end
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_reg <= `ODC_RST_PAGE;
            err_reg <= `ODC_RST_ERR;
            hp_reg <= `ODC_RST_HP;
            spk_reg <= `ODC_RST_SPK;
            rdata_reg <= 8'h00;
            gain_reg <= 7'h00;
            limit_reg <= 1'b0;
        end else begin
            page_reg <= page_next;
            err_reg <= err_next;
            hp_reg <= hp_next;
            spk_reg <= spk_next;
            rdata_reg <= rdata_next;
            gain_reg <= gain_next;
            limit_reg <= limit_next;
        end
    end

    // Outputs straight from the state registers
    assign rdata = rdata_reg;
    assign page = page_reg;
    assign drv.hpl_on = hp_reg[`ODC_BIT_HPL];
    assign drv.hpr_on = hp_reg[`ODC_BIT_HPR];
    assign drv.spk_on = spk_reg[`ODC_BIT_SPK_PWR];
    assign drv.cm_sel = hp_reg[4:3];
    assign drv.hp_limit = limit_reg;

    // Speaker short clears the speaker power bit
    spk_clear_a: assert property (@(posedge clk) disable iff (rst)
        spk_short && !err_reg[1] |=> !spk_reg[7])
        else $error("speaker power not cleared on short");

    // Keep bit set: speaker power left alone
    spk_keep_a: assert property (@(posedge clk) disable iff (rst)
        spk_short && err_reg[1] && !(req.wr && on_drv && req.addr == 8'h20)
        |=> spk_reg[7] == $past(spk_reg[7]))
        else $error("speaker power changed while kept");

    // Headphone short with action set drops both drivers
    hp_clear_a: assert property (@(posedge clk) disable iff (rst)
        hp_short && !err_reg[0] && hp_reg[1] |=> !hp_reg[7] && !hp_reg[6])
        else $error("headphone power not cleared on short");

    // Action bit clear means limiting instead
    hp_limit_a: assert property (@(posedge clk) disable iff (rst)
        hp_short && !hp_reg[1] |=> drv.hp_limit)
        else $error("current limit not applied");

    // Status bit follows the live short
    short_flag_a: assert property (@(posedge clk) disable iff (rst)
        hp_reg[0] == $past(hp_short))
        else $error("short status wrong");

    // Page select takes any written value
    page_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && req.addr == 8'h00 |=> page_reg == $past(req.wdata))
        else $error("page select not stored");

    // Page stays until rewritten
    page_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(req.wr && req.addr == 8'h00) |=> $stable(page_reg))
        else $error("page changed without write");

    // Gain readback carries the pin code
    gain_read_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && page_reg == 8'h00 && req.addr == 8'h75
        |=> rdata == {1'b0, $past(gain_reg)})
        else $error("gain readback wrong");

    // Top bit of the gain readback stays zero
    gain_top_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && page_reg == 8'h00 && req.addr == 8'h75 |=> !rdata[7])
        else $error("gain readback bit 7 set");

    // Keep bit set: headphone power left alone
    hp_keep_a: assert property (@(posedge clk) disable iff (rst)
        hp_short && err_reg[0] && !(req.wr && on_drv && req.addr == 8'h1f)
        |=> hp_reg[7:6] == $past(hp_reg[7:6]))
        else $error("headphone power changed while kept");

    // Limiting mode leaves headphone power alone
    act_keep_a: assert property (@(posedge clk) disable iff (rst)
        hp_short && !hp_reg[1] && !(req.wr && on_drv && req.addr == 8'h1f)
        |=> hp_reg[7:6] == $past(hp_reg[7:6]))
        else $error("headphone power changed while limiting");

    // No short, no limiting
    limit_off_a: assert property (@(posedge clk) disable iff (rst)
        !hp_short |=> !drv.hp_limit)
        else $error("current limit without short");

    // Headphone write lands in the power and mode bits
    hp_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && on_drv && req.addr == 8'h1f && !hp_short
        |=> hp_reg[7:1] == $past(req.wdata[7:1]))
        else $error("headphone write not stored");

    // Common-mode output follows the written code
    cm_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && on_drv && req.addr == 8'h1f
        |=> drv.cm_sel == $past(req.wdata[4:3]))
        else $error("common mode code not applied");

    // Speaker power bit takes a write when no short
    spk_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && on_drv && req.addr == 8'h20 && !spk_short
        |=> spk_reg[7] == $past(req.wdata[7]))
        else $error("speaker power write not stored");

    // Error control keeps its two live bits
    err_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && on_drv && req.addr == 8'h1e
        |=> err_reg[1:0] == $past(req.wdata[1:0]))
        else $error("error control write not stored");

    // Status bit ignores a written one
    hp_status_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && on_drv && req.addr == 8'h1f && !hp_short
        |=> !hp_reg[0])
        else $error("short status took written value");

    // Driver registers hidden off their page
    drv_read_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && page_reg != 8'h01 && req.addr == 8'h1f
        |=> rdata == 8'h00)
        else $error("driver register seen off page");

    // Page select readable on every page
    page_read_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == 8'h00 |=> rdata == $past(page_reg))
        else $error("page select readback wrong");

    // Read data is zero outside a read answer
    idle_read_a: assert property (@(posedge clk) disable iff (rst)
        !req.rd |=> rdata == 8'h00)
        else $error("read data not idle");
endmodule

/* tb_odc_regs.sv */
// Self-checking bench for the output driver control registers
module tb_top import odc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } odc_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    odc_req_t req = '0;
    logic [6:0] gain_code = 7'h00;
    logic hp_short = 1'b0;
    logic spk_short = 1'b0;
    logic [7:0] rdata;
    logic [7:0] page;
    odc_drv_t drv;
    int failures = 0;
    int checked = 0;
    // Page 1 writes and the value each should read back
    odc_row_t rows [4] = '{'{8'h1e, 8'hff, 8'h03}, '{8'h1f, 8'hdf, 8'hde},
        '{8'h20, 8'h87, 8'h86}, '{8'h10, 8'h55, 8'h00}};
    logic [6:0] codes [5] = '{7'h00, 7'h24, 7'h5b, 7'h7e, 7'h7f};
    always #25 clk = ~clk;
    odc_regs u_dut (.clk(clk), .rst(rst), .req(req), .gain_code(gain_code),
        .hp_short(hp_short), .spk_short(spk_short), .rdata(rdata),
        .page(page), .drv(drv));
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    // Read strobe, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(page, 8'h00);
        chk({2'h0, drv}, 8'h00);
        wr(8'h00, 8'h01);
        rd(8'h1f, 8'h04);
        rd(8'h20, 8'h06);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].exp);
        end
        chk({2'h0, drv}, 8'h3e);
        // Shorts with both keep bits set leave power alone
        @(posedge clk);
        hp_short <= 1'b1;
        spk_short <= 1'b1;
        settle();
        chk({2'h0, drv}, 8'h3e);
        rd(8'h1f, 8'hdf);
        @(posedge clk);
        hp_short <= 1'b0;
        spk_short <= 1'b0;
        wr(8'h1e, 8'h00);
        @(posedge clk);
        hp_short <= 1'b1;
        spk_short <= 1'b1;
        settle();
        chk({2'h0, drv}, 8'h06);
        rd(8'h1f, 8'h1f);
        rd(8'h20, 8'h06);
        // Action bit clear: current limit, power kept
        @(posedge clk);
        hp_short <= 1'b0;
        wr(8'h1f, 8'hd4);
        @(posedge clk);
        hp_short <= 1'b1;
        settle();
        chk({2'h0, drv}, 8'h35);
        @(posedge clk);
        hp_short <= 1'b0;
        settle();
        chk({2'h0, drv}, 8'h34);
        rd(8'h1f, 8'hd4);
        // Gain readback on page 0
        wr(8'h00, 8'h00);
        foreach (codes[i]) begin
            @(posedge clk);
            gain_code <= codes[i];
            settle();
            rd(8'h75, {1'b0, codes[i]});
        end
        rd(8'h1e, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'hff);
        rd(8'h1f, 8'h00);
        complete_run();
    end
endmodule
